// ### hw/usbcr_pkg.sv
package usbcr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_MAIN_STATUS   = 7'h00;
  localparam logic [6:0] IDX_DEV_STATUS    = 7'h01;
  localparam logic [6:0] IDX_HOST_STATUS   = 7'h02;
  localparam logic [6:0] IDX_CPU_STATUS    = 7'h03;
  localparam logic [6:0] IDX_FIFO_STATUS   = 7'h04;
  localparam logic [6:0] IDX_MAIN_ENABLE   = 7'h08;
  localparam logic [6:0] IDX_DEV_ENABLE    = 7'h09;
  localparam logic [6:0] IDX_HOST_ENABLE   = 7'h0A;
  localparam logic [6:0] IDX_CPU_ENABLE    = 7'h0B;
  localparam logic [6:0] IDX_FIFO_ENABLE   = 7'h0C;
  localparam logic [6:0] IDX_REVISION      = 7'h10;
  localparam logic [6:0] IDX_CHIP_RESET    = 7'h11;
  localparam logic [6:0] IDX_POWER_STATE   = 7'h12;
  localparam logic [6:0] IDX_WAKE_HIGH     = 7'h14;
  localparam logic [6:0] IDX_WAKE_LOW      = 7'h15;
  localparam logic [6:0] IDX_BUS_POWER     = 7'h16;
  localparam logic [6:0] IDX_XCVR_CONTROL  = 7'h17;
  localparam logic [6:0] IDX_DEV_LINE      = 7'h18;
  localparam logic [6:0] IDX_HOST_LINE     = 7'h19;
  localparam logic [6:0] IDX_TEST_MODE     = 7'h1B;
  localparam logic [6:0] IDX_ROLE_SELECT   = 7'h1F;
  localparam logic [6:0] IDX_BUS_SETUP     = 7'h7E;

  // Group layout: the enable of a group sits eight indices above its status
  localparam logic [6:0] GROUP_ENABLE_STEP = 7'h08;
  localparam int         GROUPS            = 4;
  // Implemented bits of device, host, cpu and fifo groups (index 0 = device)
  localparam logic [GROUPS-1:0][7:0] GROUP_MASK = {8'h87, 8'h83, 8'hFB, 8'hBB};
  localparam logic [7:0] MAIN_MASK         = 8'hF1;
  localparam int         MAIN_FINISHED_BIT = 0;
  localparam int         MAIN_GROUP_LSB    = 4;

  // Reset values and the test mode write mask
  localparam logic [7:0] CHIP_RESET_RESET  = 8'h80;
  localparam logic [7:0] XCVR_RESET        = 8'h91;
  localparam logic [7:0] ZERO_RESET        = 8'h00;
  localparam logic [7:0] TEST_MODE_MASK    = 8'h33;

  // Field positions
  localparam int SETUP_ORDER_HI = 10;
  localparam int SETUP_WIDTH_HI = 9;
  localparam int SETUP_ORDER_LO = 2;
  localparam int SETUP_WIDTH_LO = 1;
  localparam int PM_GO_SLEEP    = 7;
  localparam int PM_GO_ACTIVE   = 6;
  localparam int PM_CPU_CUT     = 5;
  localparam int CHIP_MODE_RST  = 7;
  localparam int CHIP_ALL_RST   = 0;
  localparam int BUS_POWER_BIT  = 7;
  localparam int ROLE_HOST_BIT  = 0;

  // Power state codes shown in the low bits of the power state register
  localparam logic [1:0] PM_CODE_SLEEP  = 2'h0;
  localparam logic [1:0] PM_CODE_WAKING = 2'h1;
  localparam logic [1:0] PM_CODE_ACTIVE = 2'h3;

  // Revision code; the value is arbitrary
  localparam logic [7:0] REVISION_CODE = 8'h5A;

  typedef enum logic [2:0] {
    PM_SLEEP  = 3'b001,
    PM_WAKING = 3'b010,
    PM_ACTIVE = 3'b100
  } usbcr_pm_type;

  typedef struct packed {
    logic byte_order;
    logic bus_width;
  } usbcr_setup_type;

  typedef struct packed {
    logic       vbus;
    logic       speed;
    logic [1:0] line_state;
  } usbcr_line_type;

endpackage : usbcr_pkg

// ### hw/usbcr_sync.sv
`timescale 1ns/1ns
module usbcr_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // Two flip-flops per pin level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : usbcr_sync

// ### hw/usbcr_int_group.sv
`timescale 1ns/1ns
module usbcr_int_group #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] set_bits,
  input  wire logic [7:0] clear_bits,
  output logic      [7:0] status
);
  logic [7:0] next_status;

  // Sticky bits, write one to clear, a new event beats the clear
  assign next_status = ((status & ~clear_bits) | set_bits) & MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 8'h00;
    end else begin
      status <= next_status;
    end
  end
endmodule : usbcr_int_group

// ### hw/usbcr_regs.sv
// Functional notes
// [R1] Until the setup word has been written, no register other than the setup word can be reached.
// [R2] While uninitialized, every write at any address is taken as a write of the setup word.
// [R3] After initialization, further accesses to the setup word are ignored and its setting is frozen.
// [R4] The setup word holds a byte-order bit and a bus-width bit, mirrored in both byte lanes.
// [R5] In the ACTIVE power state every register bit reads its held value, which is its reset value after reset.
// [R6] In the SLEEP power state only a chosen subset of bits reads back, all others read zero.
// [R7] The block is in the SLEEP power state as soon as reset is released.
// [R8] Each group bit of the main status shows whether any enabled bit of that group's status is set.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module usbcr_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [7:0]                 device_events,
  input  wire logic [7:0]                 host_events,
  input  wire logic [7:0]                 cpu_events,
  input  wire logic [7:0]                 fifo_events,
  input  wire usbcr_pkg::usbcr_line_type  device_line_pins,
  input  wire usbcr_pkg::usbcr_line_type  host_line_pins,
  output usbcr_pkg::usbcr_setup_type      bus_setup,
  output logic                            initialized,
  output logic                            power_active,
  output logic                            cpu_cut,
  output logic                            all_reset,
  output logic                            test_mode_reset,
  output logic      [7:0]                 xcvr_control,
  output logic      [7:0]                 test_mode,
  output logic                            bus_power_enable,
  output logic                            role_host,
  output logic                            irq
);
  // Line pins come from outside the clock domain: two flip-flops each
  usbcr_pkg::usbcr_line_type dev_line;
  usbcr_pkg::usbcr_line_type host_line;
  usbcr_sync #(.W(4)) u_dev_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (device_line_pins),
    .sync_out (dev_line)
  );
  usbcr_sync #(.W(4)) u_host_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (host_line_pins),
    .sync_out (host_line)
  );

  // Bus phases and address decode
  logic        setup_phase;
  logic        access_phase;
  logic        wr_access;
  logic        aligned;
  logic [6:0]  idx;
  logic        mapped;
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access    = access_phase & pwrite;
  assign aligned      = (paddr[1:0] == 2'h0) && ((paddr >> 9) == '0);
  assign idx          = paddr[8:2];

  // Register index known to the map
  function automatic logic is_mapped(input logic [6:0] i);
    is_mapped = (i <= usbcr_pkg::IDX_FIFO_STATUS) ||
                (i >= usbcr_pkg::IDX_MAIN_ENABLE && i <= usbcr_pkg::IDX_FIFO_ENABLE) ||
                (i >= usbcr_pkg::IDX_REVISION && i <= usbcr_pkg::IDX_POWER_STATE) ||
                (i >= usbcr_pkg::IDX_WAKE_HIGH && i <= usbcr_pkg::IDX_HOST_LINE) ||
                (i == usbcr_pkg::IDX_TEST_MODE) || (i == usbcr_pkg::IDX_ROLE_SELECT) ||
                (i == usbcr_pkg::IDX_BUS_SETUP);
  endfunction : is_mapped

  // Bits that still read back in SLEEP
  function automatic logic [7:0] sleep_mask(input logic [6:0] i);
    if (i == usbcr_pkg::IDX_MAIN_STATUS || i == usbcr_pkg::IDX_MAIN_ENABLE ||
        i == usbcr_pkg::IDX_CHIP_RESET || i == usbcr_pkg::IDX_POWER_STATE ||
        i == usbcr_pkg::IDX_WAKE_HIGH || i == usbcr_pkg::IDX_WAKE_LOW ||
        i == usbcr_pkg::IDX_ROLE_SELECT) begin
      sleep_mask = 8'hFF;
    end else begin
      sleep_mask = 8'h00;
    end
  endfunction : sleep_mask

  assign mapped = aligned && is_mapped(idx);

  // Write strobes, only after initialization and never to the setup word
  logic uninit;
  logic reg_wr;
  assign reg_wr = wr_access & ~uninit & mapped & (idx != usbcr_pkg::IDX_BUS_SETUP); // [R1] [R3]
  function automatic logic hit(input logic [6:0] i, input logic [6:0] want);
    hit = (i == want);
  endfunction : hit

  // Setup word and uninitialized period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uninit    <= 1'b1;
      bus_setup <= '0;
    end else if (wr_access && uninit) begin // [R2]
      uninit               <= 1'b0;
      bus_setup.byte_order <= pwdata[usbcr_pkg::SETUP_ORDER_LO] | pwdata[usbcr_pkg::SETUP_ORDER_HI]; // [R4]
      bus_setup.bus_width  <= pwdata[usbcr_pkg::SETUP_WIDTH_LO] | pwdata[usbcr_pkg::SETUP_WIDTH_HI]; // [R4]
    end
  end
  assign initialized = ~uninit;

  // Interrupt groups: device, host, cpu, fifo
  logic [usbcr_pkg::GROUPS-1:0][7:0] grp_events;
  logic [usbcr_pkg::GROUPS-1:0][7:0] grp_status;
  logic [usbcr_pkg::GROUPS-1:0][7:0] grp_enable;
  logic [usbcr_pkg::GROUPS-1:0]      grp_pending;
  assign grp_events = {fifo_events, cpu_events, host_events, device_events};

  genvar g;
  generate
    for (g = 0; g < usbcr_pkg::GROUPS; g++) begin : gen_group
      localparam logic [6:0] STAT_IDX = usbcr_pkg::IDX_DEV_STATUS + 7'(g);
      logic [7:0] clr;
      assign clr = (reg_wr && hit(idx, STAT_IDX)) ? pwdata[7:0] : 8'h00;
      usbcr_int_group #(.MASK(usbcr_pkg::GROUP_MASK[g])) u_group (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_bits   (grp_events[g]),
        .clear_bits (clr),
        .status     (grp_status[g])
      );
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          grp_enable[g] <= usbcr_pkg::ZERO_RESET;
        end else if (reg_wr && hit(idx, STAT_IDX + usbcr_pkg::GROUP_ENABLE_STEP)) begin
          grp_enable[g] <= pwdata[7:0] & usbcr_pkg::GROUP_MASK[g];
        end
      end
      // Group summary toward the main status
      assign grp_pending[g] = |(grp_status[g] & grp_enable[g]); // [R8]
    end
  endgenerate

  // Power state machine: SLEEP out of reset, WAKING while the wake timer runs down
  usbcr_pkg::usbcr_pm_type pm_state;
  usbcr_pkg::usbcr_pm_type next_pm_state;
  logic [15:0]             wake_count;
  logic [15:0]             next_wake_count;
  logic [7:0]              wake_high;
  logic [7:0]              wake_low;
  logic                    pm_done;
  logic                    pm_wr;
  logic                    go_sleep;
  logic                    go_active;
  assign pm_wr     = reg_wr && hit(idx, usbcr_pkg::IDX_POWER_STATE);
  assign go_sleep  = pm_wr & pwdata[usbcr_pkg::PM_GO_SLEEP];
  assign go_active = pm_wr & pwdata[usbcr_pkg::PM_GO_ACTIVE];
  always_comb begin
    next_pm_state   = pm_state;
    next_wake_count = wake_count;
    pm_done         = 1'b0;
    case (pm_state)
      usbcr_pkg::PM_SLEEP: begin
        if (go_active) begin
          next_pm_state   = usbcr_pkg::PM_WAKING;
          next_wake_count = {wake_high, wake_low};
        end
      end
      usbcr_pkg::PM_WAKING: begin
        if (go_sleep) begin
          next_pm_state = usbcr_pkg::PM_SLEEP;
          pm_done       = 1'b1;
        end else if (wake_count == 16'h0000) begin
          next_pm_state = usbcr_pkg::PM_ACTIVE;
          pm_done       = 1'b1;
        end else begin
          next_wake_count = wake_count - 16'h0001;
        end
      end
      usbcr_pkg::PM_ACTIVE: begin
        if (go_sleep) begin
          next_pm_state = usbcr_pkg::PM_SLEEP;
          pm_done       = 1'b1;
        end
      end
      default: begin
        next_pm_state = usbcr_pkg::PM_SLEEP;
      end
    endcase
  end

  // State and timer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_state   <= usbcr_pkg::PM_SLEEP; // [R7]
      wake_count <= 16'h0000;
    end else begin
      pm_state   <= next_pm_state;
      wake_count <= next_wake_count;
    end
  end
  assign power_active = (pm_state == usbcr_pkg::PM_ACTIVE);

  // State code shown in the power state register
  function automatic logic [1:0] pm_code(input usbcr_pkg::usbcr_pm_type s);
    case (s)
      usbcr_pkg::PM_ACTIVE: pm_code = usbcr_pkg::PM_CODE_ACTIVE;
      usbcr_pkg::PM_WAKING: pm_code = usbcr_pkg::PM_CODE_WAKING;
      default:              pm_code = usbcr_pkg::PM_CODE_SLEEP;
    endcase
  endfunction : pm_code

  // Write strobes of the plain registers
  logic main_stat_wr;
  logic main_en_wr;
  logic chip_wr;
  logic wake_hi_wr;
  logic wake_lo_wr;
  logic bus_power_wr;
  logic xcvr_wr;
  logic test_mode_wr;
  logic role_wr;
  assign main_stat_wr = reg_wr && hit(idx, usbcr_pkg::IDX_MAIN_STATUS);
  assign main_en_wr   = reg_wr && hit(idx, usbcr_pkg::IDX_MAIN_ENABLE);
  assign chip_wr      = reg_wr && hit(idx, usbcr_pkg::IDX_CHIP_RESET);
  assign wake_hi_wr   = reg_wr && hit(idx, usbcr_pkg::IDX_WAKE_HIGH);
  assign wake_lo_wr   = reg_wr && hit(idx, usbcr_pkg::IDX_WAKE_LOW);
  assign bus_power_wr = reg_wr && hit(idx, usbcr_pkg::IDX_BUS_POWER);
  assign xcvr_wr      = reg_wr && hit(idx, usbcr_pkg::IDX_XCVR_CONTROL);
  assign test_mode_wr = reg_wr && hit(idx, usbcr_pkg::IDX_TEST_MODE);
  assign role_wr      = reg_wr && hit(idx, usbcr_pkg::IDX_ROLE_SELECT);

  // Plain registers; the all-reset bit drops again one cycle after it is written
  logic [7:0] main_enable;
  logic [7:0] chip_reset;
  logic       cpu_cut_hold;
  logic       bus_power;
  logic [7:0] xcvr_reg;
  logic [7:0] test_mode_reg;
  logic       role_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_enable   <= usbcr_pkg::ZERO_RESET;
      chip_reset    <= usbcr_pkg::CHIP_RESET_RESET;
      cpu_cut_hold  <= 1'b0;
      wake_high     <= usbcr_pkg::ZERO_RESET;
      wake_low      <= usbcr_pkg::ZERO_RESET;
      bus_power     <= 1'b0;
      xcvr_reg      <= usbcr_pkg::XCVR_RESET;
      test_mode_reg <= usbcr_pkg::ZERO_RESET;
      role_reg      <= 1'b0;
    end else begin
      main_enable   <= main_en_wr ? (pwdata[7:0] & usbcr_pkg::MAIN_MASK) : main_enable;
      chip_reset    <= chip_wr ? {pwdata[usbcr_pkg::CHIP_MODE_RST], 6'h00, pwdata[usbcr_pkg::CHIP_ALL_RST]}
                               : {chip_reset[usbcr_pkg::CHIP_MODE_RST], 7'h00};
      cpu_cut_hold  <= pm_wr ? pwdata[usbcr_pkg::PM_CPU_CUT] : cpu_cut_hold;
      wake_high     <= wake_hi_wr ? pwdata[7:0] : wake_high;
      wake_low      <= wake_lo_wr ? pwdata[7:0] : wake_low;
      bus_power     <= bus_power_wr ? pwdata[usbcr_pkg::BUS_POWER_BIT] : bus_power;
      xcvr_reg      <= xcvr_wr ? pwdata[7:0] : xcvr_reg;
      test_mode_reg <= test_mode_wr ? (pwdata[7:0] & usbcr_pkg::TEST_MODE_MASK) : test_mode_reg;
      role_reg      <= role_wr ? pwdata[usbcr_pkg::ROLE_HOST_BIT] : role_reg;
    end
  end

  // Finished flag of the power machine: sticky, a new event beats the clear
  logic finished_pm;
  logic next_finished_pm;
  assign next_finished_pm = pm_done | (finished_pm & ~(main_stat_wr & pwdata[usbcr_pkg::MAIN_FINISHED_BIT]));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      finished_pm <= 1'b0;
    end else begin
      finished_pm <= next_finished_pm;
    end
  end

  // Main status: one summary bit per group, device group in the top bit
  logic [7:0] main_status;
  assign main_status = {grp_pending[0], grp_pending[1], grp_pending[2], grp_pending[3], 3'h0, finished_pm}; // [R8]
  assign irq         = |(main_status & main_enable);

  // Outputs toward the rest of the controller
  assign cpu_cut          = cpu_cut_hold;
  assign all_reset        = chip_reset[usbcr_pkg::CHIP_ALL_RST];
  assign test_mode_reset  = chip_reset[usbcr_pkg::CHIP_MODE_RST];
  assign xcvr_control     = xcvr_reg;
  assign test_mode        = test_mode_reg;
  assign bus_power_enable = bus_power;
  assign role_host        = role_reg;

  // Read selection of the addressed register
  logic [1:0] grp_sel;
  logic [7:0] read_value;
  logic [7:0] sleep_bits;
  logic [7:0] read_byte;
  assign grp_sel = idx[1:0] - 2'h1;
  always_comb begin
    read_value = 8'h00;
    if (idx == usbcr_pkg::IDX_MAIN_STATUS) begin
      read_value = main_status;
    end else if (idx >= usbcr_pkg::IDX_DEV_STATUS && idx <= usbcr_pkg::IDX_FIFO_STATUS) begin
      read_value = grp_status[grp_sel];
    end else if (idx == usbcr_pkg::IDX_MAIN_ENABLE) begin
      read_value = main_enable;
    end else if (idx >= usbcr_pkg::IDX_DEV_ENABLE && idx <= usbcr_pkg::IDX_FIFO_ENABLE) begin
      read_value = grp_enable[grp_sel];
    end else if (idx == usbcr_pkg::IDX_REVISION) begin
      read_value = usbcr_pkg::REVISION_CODE;
    end else if (idx == usbcr_pkg::IDX_CHIP_RESET) begin
      read_value = chip_reset;
    end else if (idx == usbcr_pkg::IDX_POWER_STATE) begin
      read_value = {2'h0, cpu_cut_hold, 3'h0, pm_code(pm_state)};
    end else if (idx == usbcr_pkg::IDX_WAKE_HIGH) begin
      read_value = wake_high;
    end else if (idx == usbcr_pkg::IDX_WAKE_LOW) begin
      read_value = wake_low;
    end else if (idx == usbcr_pkg::IDX_BUS_POWER) begin
      read_value = {bus_power, 7'h00};
    end else if (idx == usbcr_pkg::IDX_XCVR_CONTROL) begin
      read_value = xcvr_reg;
    end else if (idx == usbcr_pkg::IDX_DEV_LINE) begin
      read_value = {dev_line.vbus, dev_line.speed, 4'h0, dev_line.line_state};
    end else if (idx == usbcr_pkg::IDX_HOST_LINE) begin
      read_value = {host_line.vbus, 5'h00, host_line.line_state};
    end else if (idx == usbcr_pkg::IDX_TEST_MODE) begin
      read_value = test_mode_reg;
    end else if (idx == usbcr_pkg::IDX_ROLE_SELECT) begin
      read_value = {7'h00, role_reg};
    end
  end
  assign sleep_bits = sleep_mask(idx);
  // Uninitialized reads see nothing; outside ACTIVE only the kept bits show
  assign read_byte  = (uninit || !mapped) ? 8'h00 :                                         // [R1]
                      power_active ? read_value : (read_value & sleep_bits);              // [R5] [R6]

  // APB answer: read data captured in the setup cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end
  assign pready  = access_phase;
  assign pslverr = access_phase & ~uninit & ~mapped;

  // Checks on the setup word, the read gating and the power machine
  sequence go_wake_s;
    go_active && pm_state == usbcr_pkg::PM_SLEEP;
  endsequence
  sequence uninit_read_s;
    setup_phase && !pwrite && uninit;
  endsequence
  setup_frozen_a: assert property (@(posedge pclk) disable iff (!presetn) initialized |=> $stable(bus_setup)) // [R3]
    else $error("setup word changed after initialization");
  uninit_write_a: assert property (@(posedge pclk) disable iff (!presetn) wr_access && uninit |=> initialized) // [R2]
    else $error("write while uninitialized did not end the period");
  uninit_read_a: assert property (@(posedge pclk) disable iff (!presetn) uninit_read_s |=> prdata == '0) // [R1]
    else $error("register visible before initialization");
  sleep_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    setup_phase && !pwrite && !uninit && !power_active |=> (prdata[7:0] & ~$past(sleep_bits)) == 8'h00)
    else $error("hidden bit visible outside ACTIVE");
  reset_sleep_a: assert property (@(posedge pclk) !presetn |=> pm_state == usbcr_pkg::PM_SLEEP) // [R7]
    else $error("not in SLEEP after reset");
  wake_start_a: assert property (@(posedge pclk) disable iff (!presetn) go_wake_s |=> pm_state == usbcr_pkg::PM_WAKING) // a wake request in SLEEP moves the power machine to WAKING
    else $error("wake request not taken");

  // Summary bit follows an enabled event of its group
  generate
    for (g = 0; g < usbcr_pkg::GROUPS; g++) begin : gen_group_chk
      localparam logic [6:0] EN_IDX = usbcr_pkg::IDX_DEV_ENABLE + 7'(g);
      group_summary_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        (|(grp_events[g] & grp_enable[g])) && !(reg_wr && hit(idx, EN_IDX)) |=> grp_pending[g])
        else $error("group summary bit missing");
    end
  endgenerate
endmodule : usbcr_regs

// ### sim/usbcr_host_model.sv
`timescale 1ns/1ns
module usbcr_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer, entered just after a rising edge; held until pready
  task automatic xfer(input logic wr, input logic [6:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {3'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : usbcr_host_model

// ### sim/test_usbcr_regs.sv
`timescale 1ns/1ns
module test_usbcr_regs;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq, initialized, power_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  device_events = 8'h00;
  usbcr_pkg::usbcr_setup_type bus_setup;
  int n_errors = 0;
  int comparisons = 0;
  // Reset values of the registers read back after waking
  logic [6:0] ridx [5] = '{usbcr_pkg::IDX_DEV_ENABLE, usbcr_pkg::IDX_CHIP_RESET, usbcr_pkg::IDX_XCVR_CONTROL,
                           usbcr_pkg::IDX_ROLE_SELECT, usbcr_pkg::IDX_MAIN_ENABLE};
  logic [7:0] rval [5] = '{8'h00, 8'h80, 8'h91, 8'h00, 8'h00};
  always #5 pclk = ~pclk;
  usbcr_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                         .pwdata(pwdata), .prdata(prdata), .pready(pready));
  usbcr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_events(device_events), .host_events(8'h00), .cpu_events(8'h00), .fifo_events(8'h00),
    .device_line_pins('0), .host_line_pins('0), .bus_setup(bus_setup), .initialized(initialized),
    .power_active(power_active), .cpu_cut(), .all_reset(), .test_mode_reset(), .xcvr_control(),
    .test_mode(), .bus_power_enable(), .role_host(), .irq(irq));
  // Compare one value
  task automatic cmp(input logic [7:0] act, input logic [7:0] exp);
    comparisons++;
    if (act !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, act, exp);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    host.xfer(1'b1, idx, {8'h00, d, 8'h00, d}, rd);
  endtask : wr
  task automatic rd_cmp(input logic [6:0] idx, input logic [7:0] exp);
    host.xfer(1'b0, idx, 32'h0000_0000, rd);
    cmp(rd[7:0], exp);
  endtask : rd_cmp
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  // Test sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp({7'h00, power_active}, 8'h00);
    cmp({7'h00, initialized}, 8'h00);
    rd_cmp(usbcr_pkg::IDX_CHIP_RESET, 8'h00);
    wr(usbcr_pkg::IDX_DEV_ENABLE, 8'h04);
    for (int i = 0; i < 20 && initialized !== 1'b1; i++) @(posedge pclk);
    cmp({7'h00, initialized}, 8'h01);
    cmp({6'h00, bus_setup}, 8'h02);
    wr(usbcr_pkg::IDX_BUS_SETUP, 8'h02);
    cmp({6'h00, bus_setup}, 8'h02);
    rd_cmp(usbcr_pkg::IDX_XCVR_CONTROL, 8'h00);
    rd_cmp(usbcr_pkg::IDX_CHIP_RESET, 8'h80);
    wr(usbcr_pkg::IDX_POWER_STATE, 8'h40);
    for (int i = 0; i < 200 && power_active !== 1'b1; i++) @(posedge pclk);
    foreach (ridx[i]) rd_cmp(ridx[i], rval[i]);
    rd_cmp(7'h05, 8'h00);
    wr(usbcr_pkg::IDX_DEV_ENABLE, 8'h01);
    device_events <= 8'h01;
    @(posedge pclk);
    device_events <= 8'h00;
    repeat (4) @(posedge pclk);
    rd_cmp(usbcr_pkg::IDX_DEV_STATUS, 8'h01);
    rd_cmp(usbcr_pkg::IDX_MAIN_STATUS, 8'h81);
    cmp({7'h00, irq}, 8'h00);
    wr(usbcr_pkg::IDX_MAIN_ENABLE, 8'h80);
    cmp({7'h00, irq}, 8'h01);
    wr(usbcr_pkg::IDX_DEV_STATUS, 8'h01);
    cmp({7'h00, irq}, 8'h00);
    rd_cmp(usbcr_pkg::IDX_MAIN_STATUS, 8'h01);
    wr(usbcr_pkg::IDX_MAIN_STATUS, 8'h01);
    rd_cmp(usbcr_pkg::IDX_MAIN_STATUS, 8'h00);
    tally_and_finish();
  end
endmodule : test_usbcr_regs
